// >>> dv/fpeof_mem_model.sv
`timescale 1ns/100ps
module fpeof_mem_model (
  input  wire logic        clk,
  input  wire logic [23:0] memAddr,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic [15:0] memWdata,
  input  wire logic [1:0]  memBe,
  output logic [15:0]      memRdata
);
  logic [7:0] mem [0:255];
  initial begin
    memRdata = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  // Outside the answer cycle the bus flips every cycle, so a sample one cycle late sees inverted data.
  always @(posedge clk) begin
    if (memRd) begin
      memRdata <= {mem[memAddr[7:0] + 8'h01], mem[memAddr[7:0]]};
    end else begin
      memRdata <= ~memRdata;
    end
    if (memWr && memBe[0]) begin
      mem[memAddr[7:0]] <= memWdata[7:0];
    end
    if (memWr && memBe[1]) begin
      mem[memAddr[7:0] + 8'h01] <= memWdata[15:8];
    end
  end
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk, resetn, regWr, regRd, excValid, excSign, fixValid, memRd, memWr;
  logic        errorN, irq, busy, rdSeen;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, memWdata, memRdata;
  logic [5:0]  excReq;
  logic [79:0] fixResult;
  logic [23:0] memAddr;
  logic [1:0]  memBe;
  logic [15:0] expQ[$];
  int          fail_count = 0;
  int          compares = 0;
  int          seed = 32'ha13d3b07;
  fpeof_unit DUT (.clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .excValid,
    .excReq, .excSign, .fixValid, .fixResult, .memAddr, .memRd, .memWr, .memWdata, .memBe,
    .memRdata, .errorN, .irq, .busy);
  fpeof_mem_model mem (.clk, .memAddr, .memRd, .memWr, .memWdata, .memBe, .memRdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  always @(posedge clk) begin
    if (rdSeen === 1'b1) begin
      chk("regRdata", {64'h0, expQ.pop_front()}, {64'h0, regRdata});
    end
    rdSeen <= regRd;
  end
  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    expQ.push_back(e);
    @(posedge clk);
  endtask
  task automatic settle;
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic exc(input logic [5:0] r, input logic fix, input logic errN);
    logic s;
    s = 1'($random(seed));
    @(posedge clk);
    excValid <= 1'b1;
    excReq <= r;
    excSign <= s;
    @(posedge clk);
    excValid <= 1'b0;
    @(negedge clk);
    chk("fixValid", 80'(fix), 80'(fixValid));
    if (fix) chk("fixResult", {s, 15'h7fff, 64'h8000_0000_0000_0000}, fixResult);
    chk("errorN", 80'(errN), 80'(errorN));
    @(posedge clk);
  endtask
  task automatic run;
    int n;
    settle();
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    if (n == 60) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    resetn = 1'b0;
    rdSeen = 1'b0;
    {regWr, regRd, regAddr, regWdata, excValid, excReq, excSign} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(fpeof_pkg::RA_CTRL, fpeof_pkg::CTRL_RESET);
    rd(fpeof_pkg::RA_COND, 16'h0000);
    rd(4'h7, 16'h0000);
    settle();
    exc(6'h04, 1'b1, 1'b1);
    rd(fpeof_pkg::RA_COND, 16'h0004);
    wr(fpeof_pkg::RA_CTRL, 16'h037a);
    wr(fpeof_pkg::RA_INTMSK, 16'h0001);
    wr(fpeof_pkg::RA_COND, 16'h003f);
    settle();
    exc(6'h07, 1'b0, 1'b0);
    rd(fpeof_pkg::RA_COND, 16'h0081);
    settle();
    chk("irq", 80'h1, 80'(irq));
    chk("errorN", 80'h0, 80'(errorN));
    @(posedge clk);
    wr(fpeof_pkg::RA_COND, 16'h003f);
    wr(fpeof_pkg::RA_INTST, 16'h0003);
    settle();
    chk("errorN", 80'h1, 80'(errorN));
    chk("irq", 80'h0, 80'(irq));
    exc(6'h01, 1'b0, 1'b0);
    wr(fpeof_pkg::RA_CMD, 16'h8000);
    settle();
    chk("errorN", 80'h1, 80'(errorN));
    @(posedge clk);
    rd(fpeof_pkg::RA_CTRL, fpeof_pkg::CTRL_RESET);
    // A 16-bit integer at an odd address spans two memory words.
    wr(fpeof_pkg::RA_ADRLO, 16'h0021);
    wr(fpeof_pkg::RA_ADRHI, 16'h0000);
    wr(fpeof_pkg::RA_CMD, 16'h0001);
    run();
    for (int w = 0; w < 5; w++) begin
      rd(4'(fpeof_pkg::RA_EXT0 + w), 16'(80'h400c_8884_0000_0000_0000 >> (16 * w)));
    end
    wr(fpeof_pkg::RA_ADRLO, 16'h0040);
    wr(fpeof_pkg::RA_CMD, 16'h000f);
    run();
    settle();
    chk("memImage", 80'h0000_4446_0884_00, {mem.mem[8'h44], mem.mem[8'h43], mem.mem[8'h42],
      mem.mem[8'h41], mem.mem[8'h40]});
    @(posedge clk);
    rd(fpeof_pkg::RA_ADRLO, 16'h0040);
    // Packed decimal goes out, then the same bytes come back as a 32-bit integer.
    wr(fpeof_pkg::RA_ADRLO, 16'h0050);
    wr(fpeof_pkg::RA_CMD, 16'h0017);
    run();
    wr(fpeof_pkg::RA_CMD, 16'h0005);
    run();
    rd(fpeof_pkg::RA_EXT0 + 4'h3, 16'h8737);
    rd(fpeof_pkg::RA_EXT0 + 4'h4, 16'h400e);
    settle();
    tally_and_finish();
  end
endmodule

// >>> rtl/fpeof_convert.sv
`timescale 1ns/100ps
module fpeof_convert (
  input  wire fpeof_pkg::fpeof_fmt_type fmt,
  input  wire logic [79:0]              memOp,
  input  wire logic [79:0]              extIn,
  output logic [79:0]                   loadExt,
  output logic [5:0]                    loadExc,
  output logic [79:0]                   storeData,
  output logic [5:0]                    storeExc
);
  // Sign, 15-bit biased exponent and explicit integer bit at 63.
  function automatic logic [79:0] norm(input logic s, input logic [63:0] m,
                                       input logic [14:0] e0);
    logic [63:0] v;
    logic [14:0] e;
    v = m;
    e = e0;
    for (int i = 0; i < 63; i++) begin
      if (!v[63] && v != 64'h0 && e > 15'h1) begin
        v = v << 1;
        e = e - 15'h1;
      end
    end
    if (m == 64'h0) e = 15'h0;
    return {s, e, v}; // RULE15
  endfunction

  function automatic logic [79:0] intLoad(input logic [63:0] v);
    return norm(v[63], v[63] ? -v : v, fpeof_pkg::EXT_BIAS + 15'd63);
  endfunction

  function automatic logic [85:0] realLoad(input logic s, input logic [10:0] e,
                                           input logic [10:0] emax, input logic [62:0] f,
                                           input logic [14:0] adj);
    logic [85:0] r;
    r = '0;
    if (e == emax) begin
      r[79:0] = {s, fpeof_pkg::EXP_MAX, 1'b1, (f != 63'h0), f[61:0]}; // RULE6
      r[80 + fpeof_pkg::EXC_INV] = (f != 63'h0) && !f[62];
    end else if (e == 11'h0) begin
      r[79:0] = norm(s, {1'b0, f}, adj + 15'h1); // RULE6
      r[80 + fpeof_pkg::EXC_DEN] = (f != 63'h0);
    end else begin
      r[79:0] = {s, adj + {4'h0, e}, 1'b1, f};
    end
    return r;
  endfunction

  function automatic logic [65:0] toMag(input logic [79:0] x);
    logic [14:0] e;
    logic [5:0]  sh;
    logic        inv;
    logic        pre;
    logic [63:0] mag;
    e = x[78:64];
    sh = '0;
    inv = 1'b0;
    pre = 1'b0;
    mag = '0;
    if (e == fpeof_pkg::EXP_MAX || (e != 15'h0 && !x[63])) inv = 1'b1;
    else if (e < fpeof_pkg::EXT_BIAS) pre = (x[63:0] != 64'h0);
    else if (e > fpeof_pkg::EXT_BIAS + 15'd62) inv = 1'b1;
    else begin
      sh = 6'(fpeof_pkg::EXT_BIAS + 15'd63 - e);
      mag = x[63:0] >> sh;
      pre = (x[63:0] & ((64'h1 << sh) - 64'h1)) != 64'h0;
    end
    return {inv, pre, mag};
  endfunction

  function automatic logic [69:0] intStore(input logic [79:0] x, input int n);
    logic [65:0] m;
    logic [63:0] lim;
    logic [69:0] r;
    m = toMag(x);
    lim = 64'h1 << (n - 1);
    r = '0;
    if (m[65] || m[63:0] >= lim) begin
      r[63:0] = lim;
      r[64 + fpeof_pkg::EXC_INV] = 1'b1;
    end else begin
      r[63:0] = x[79] ? -m[63:0] : m[63:0];
      r[64 + fpeof_pkg::EXC_PRE] = m[64];
    end
    return r;
  endfunction

  function automatic logic [69:0] realStore(input logic [79:0] x, input logic [14:0] adj,
                                            input logic [10:0] emax, input int fb);
    logic [14:0]        e;
    logic signed [16:0] ne;
    logic [10:0]        eo;
    logic [51:0]        fo;
    logic [5:0]         ex;
    e = x[78:64];
    ne = $signed({2'b00, e}) - $signed({2'b00, adj});
    eo = '0;
    fo = 52'(x[62:0] >> (63 - fb));
    ex = '0;
    if (e != 15'h0 && !x[63]) begin
      eo = emax;
      fo = 52'h1 << (fb - 1);
      ex[fpeof_pkg::EXC_INV] = 1'b1;
    end else if (e == fpeof_pkg::EXP_MAX) begin
      eo = emax;
      if (x[62:0] != 63'h0) fo[fb - 1] = 1'b1;
      ex[fpeof_pkg::EXC_INV] = (x[62:0] != 63'h0) && !x[62];
    end else if (x[63:0] == 64'h0) begin
      fo = '0;
    end else if (ne >= $signed({6'h0, emax})) begin
      eo = emax; // RULE13
      fo = '0;
      ex[fpeof_pkg::EXC_OVF] = 1'b1;
      ex[fpeof_pkg::EXC_PRE] = 1'b1;
    end else if (ne <= 17'sd0) begin
      fo = '0; // RULE13
      ex[fpeof_pkg::EXC_UNF] = 1'b1;
      ex[fpeof_pkg::EXC_PRE] = 1'b1;
    end else begin
      eo = ne[10:0];
      ex[fpeof_pkg::EXC_PRE] = 63'(x[62:0] << fb) != 63'h0;
    end
    return {ex, x[79], eo, fo};
  endfunction

  always_comb begin
    logic [85:0] rl;
    logic [69:0] rs;
    logic [65:0] m;
    logic [63:0] acc;
    logic [63:0] q;
    logic [71:0] dg;
    rl = '0;
    rs = '0;
    acc = '0;
    dg = '0;
    m = toMag(extIn);
    q = m[63:0];
    loadExc = '0;
    storeExc = '0;
    storeData = '0;
    for (int i = 17; i >= 0; i--) acc = acc * 64'd10 + {60'h0, memOp[4 * i +: 4]};
    for (int i = 0; i < 18; i++) begin
      dg[4 * i +: 4] = 4'(q % 64'd10);
      q = q / 64'd10;
    end
    case (fmt) // RULE5
      fpeof_pkg::FMT_I16: loadExt = intLoad({{48{memOp[15]}}, memOp[15:0]}); // RULE3
      fpeof_pkg::FMT_I32: loadExt = intLoad({{32{memOp[31]}}, memOp[31:0]});
      fpeof_pkg::FMT_I64: loadExt = intLoad(memOp[63:0]);
      fpeof_pkg::FMT_R32: begin
        rl = realLoad(memOp[31], {3'h0, memOp[30:23]}, fpeof_pkg::S_EMAX,
                      {memOp[22:0], 40'h0}, fpeof_pkg::S_ADJ);
        loadExt = rl[79:0];
        loadExc = rl[85:80];
      end
      fpeof_pkg::FMT_R64: begin
        rl = realLoad(memOp[63], memOp[62:52], fpeof_pkg::D_EMAX,
                      {memOp[51:0], 11'h0}, fpeof_pkg::D_ADJ);
        loadExt = rl[79:0];
        loadExc = rl[85:80];
      end
      fpeof_pkg::FMT_BCD: loadExt = norm(memOp[79], acc, fpeof_pkg::EXT_BIAS + 15'd63);
      default: begin
        loadExt = memOp;
        if (memOp[78:64] != 15'h0 && !memOp[63]) begin
          loadExt = fpeof_pkg::QNAN_IND; // RULE6
          loadExc[fpeof_pkg::EXC_INV] = 1'b1;
        end else if (memOp[78:64] == fpeof_pkg::EXP_MAX) begin
          loadExt[62] = loadExt[62] | (memOp[61:0] != 62'h0);
          loadExc[fpeof_pkg::EXC_INV] = !memOp[62] && (memOp[61:0] != 62'h0);
        end else begin
          loadExc[fpeof_pkg::EXC_DEN] = (memOp[78:64] == 15'h0) && (memOp[63:0] != 64'h0);
        end
      end
    endcase
    case (fmt) // RULE4
      fpeof_pkg::FMT_I16, fpeof_pkg::FMT_I32, fpeof_pkg::FMT_I64: begin
        rs = intStore(extIn, 8 * fpeof_pkg::fmt_bytes(fmt));
        storeData = {16'h0, rs[63:0]};
        storeExc = rs[69:64];
      end
      fpeof_pkg::FMT_R32: begin
        rs = realStore(extIn, fpeof_pkg::S_ADJ, fpeof_pkg::S_EMAX, fpeof_pkg::S_FB);
        storeData = {48'h0, rs[63], rs[59:52], rs[22:0]};
        storeExc = rs[69:64];
      end
      fpeof_pkg::FMT_R64: begin
        rs = realStore(extIn, fpeof_pkg::D_ADJ, fpeof_pkg::D_EMAX, fpeof_pkg::D_FB);
        storeData = {16'h0, rs[63:0]};
        storeExc = rs[69:64];
      end
      fpeof_pkg::FMT_BCD: begin
        if (m[65] || m[63:0] > fpeof_pkg::BCD_MAX) begin
          storeData = fpeof_pkg::QNAN_IND; // RULE13
          storeExc[fpeof_pkg::EXC_INV] = 1'b1;
        end else begin
          storeData = {extIn[79], 7'h0, dg};
          storeExc[fpeof_pkg::EXC_PRE] = m[64];
        end
      end
      default: storeData = extIn;
    endcase
  end
endmodule

// >>> rtl/fpeof_pkg.sv
package fpeof_pkg;
  localparam int DW        = 16;
  localparam int EXC_N     = 6;
  localparam int EXC_INV   = 0;
  localparam int EXC_DEN   = 1;
  localparam int EXC_ZDV   = 2;
  localparam int EXC_OVF   = 3;
  localparam int EXC_UNF   = 4;
  localparam int EXC_PRE   = 5;
  localparam int ES_BIT    = 7;
  localparam logic [15:0] CTRL_RESET = 16'h037f;
  localparam int RA_W      = 4;
  localparam logic [3:0] RA_CTRL   = 4'h0;
  localparam logic [3:0] RA_COND   = 4'h1;
  localparam logic [3:0] RA_INTST  = 4'h2;
  localparam logic [3:0] RA_INTMSK = 4'h3;
  localparam logic [3:0] RA_CMD    = 4'h4;
  localparam logic [3:0] RA_ADRLO  = 4'h5;
  localparam logic [3:0] RA_ADRHI  = 4'h6;
  localparam logic [3:0] RA_EXT0   = 4'h8;
  localparam int EXT_WORDS = 5;
  localparam int CMD_GO    = 0;
  localparam int CMD_STORE = 1;
  localparam int CMD_FMT   = 2;
  localparam int CMD_INIT  = 15;
  localparam int INT_FAULT = 0;
  localparam int INT_DONE  = 1;
  localparam int INT_N     = 2;
  localparam int CNT_W     = 3;
  localparam int RAW_W     = 96;
  typedef enum logic [2:0] {
    FMT_I16 = 3'h0, FMT_I32 = 3'h1, FMT_I64 = 3'h2, FMT_R32 = 3'h3,
    FMT_R64 = 3'h4, FMT_BCD = 3'h5, FMT_EXT = 3'h6
  } fpeof_fmt_type;
  localparam logic [14:0] EXT_BIAS = 15'h3fff;
  localparam logic [14:0] EXP_MAX  = 15'h7fff;
  localparam logic [14:0] S_ADJ    = 15'h3f80;
  localparam logic [14:0] D_ADJ    = 15'h3c00;
  localparam logic [10:0] S_EMAX   = 11'h0ff;
  localparam logic [10:0] D_EMAX   = 11'h7ff;
  localparam int S_FB = 23;
  localparam int D_FB = 52;
  localparam logic [79:0] QNAN_IND = 80'hffff_c000_0000_0000_0000;
  localparam logic [63:0] BCD_MAX  = 64'h0de0_b6b3_a763_ffff;

  function automatic int fmt_bytes(input fpeof_fmt_type f);
    case (f)
      FMT_I16: return 2;
      FMT_I32, FMT_R32: return 4;
      FMT_I64, FMT_R64: return 8;
      default: return 10;
    endcase
  endfunction
endpackage

// >>> rtl/fpeof_unit.sv
`timescale 1ns/100ps
// What the document requires
// RULE1: Memory operands go least significant byte first, starting at lowest address.
// RULE2: Operands at any byte address; misaligned ones cost extra memory cycles.
// RULE3: Loads convert integer, real and packed decimal operands to extended precision.
// RULE4: Stores convert extended precision back to the selected memory format.
// RULE5: Binary integer, decimal integer and binary real formats exist only in memory.
// RULE6: Denormals, signed zeros, infinities, NaNs, indefinite and unsupported are handled.
// RULE7: Six exception conditions, resolved in a fixed precedence order.
// RULE8: A masked exception is not reported; its default action is taken.
// RULE9: Unmasked exception sets its flag, the summary fault bit and drives errorN low.
// RULE10: Host raises interrupt 16 on its next coprocessor or wait instruction.
// RULE11: Host records instruction and operand addresses of each coprocessor instruction.
// RULE12: Six mask bits sit in the low bits of the control setting word.
// RULE13: Masked defaults: quiet NaN or indefinite, infinity, largest value, denormal or zero; the code never gives the largest value or a denormal.
// RULE14: Fault output and summary bit hold until flags cleared or device reinitialised.
// RULE15: Extended format: sign at bit 79, 15-bit biased exponent, 64-bit significand.
module fpeof_unit #(
  parameter int AW = 24
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [3:0]    regAddr,
  input  wire logic [15:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic [15:0]        regRdata,
  input  wire logic          excValid,
  input  wire logic [5:0]    excReq,
  input  wire logic          excSign,
  output logic               fixValid,
  output logic [79:0]        fixResult,
  output logic [AW-1:0]      memAddr,
  output logic               memRd,
  output logic               memWr,
  output logic [15:0]        memWdata,
  output logic [1:0]         memBe,
  input  wire logic [15:0]   memRdata,
  output logic               errorN,
  output logic               irq,
  output logic               busy
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_RISS  = 6'b000010,
    S_RWAIT = 6'b000100,
    S_RCAP  = 6'b001000,
    S_LFIN  = 6'b010000,
    S_WRITE = 6'b100000
  } fpeof_state_type;

  typedef struct packed {
    logic [15:0]              ctrl;
    logic [5:0]               flags;
    logic                     es;
    logic [1:0]               intSt;
    logic [1:0]               intMsk;
    fpeof_pkg::fpeof_fmt_type fmt;
    logic                     store;
    logic [AW-1:0]            addr;
    logic [79:0]              ext;
    logic [95:0]              raw;
    logic [2:0]               cnt;
    fpeof_state_type          st;
    logic                     memRd;
    logic                     memWr;
    logic [AW-1:0]            memAddr;
    logic [15:0]              memWdata;
    logic [1:0]               memBe;
    logic [15:0]              rdData;
    logic [79:0]              fixRes;
    logic                     fixVal;
  } fpeof_regs_type;

  localparam fpeof_regs_type REGS_RST = '{
    ctrl: fpeof_pkg::CTRL_RESET, st: S_IDLE, fmt: fpeof_pkg::FMT_I16, default: '0
  };

  // Highest precedence condition wins; inexact may ride along with a range error.
  function automatic logic [5:0] resolve(input logic [5:0] raw);
    logic [5:0] r;
    r = '0;
    for (int i = fpeof_pkg::EXC_N - 1; i >= 0; i--) begin
      if (raw[i]) r = 6'h1 << i; // RULE7
    end
    if (r[fpeof_pkg::EXC_OVF] || r[fpeof_pkg::EXC_UNF]) r[fpeof_pkg::EXC_PRE] = raw[fpeof_pkg::EXC_PRE];
    return r;
  endfunction

  function automatic logic [2:0] wordsFor(input fpeof_pkg::fpeof_fmt_type f, input logic off);
    return 3'((fpeof_pkg::fmt_bytes(f) + int'(off) + 1) >> 1); // RULE2
  endfunction

  logic [1:0]               rstPipe;
  logic                     rstN;
  fpeof_regs_type           q;
  fpeof_regs_type           n;
  fpeof_pkg::fpeof_fmt_type cvFmt;
  logic [79:0]              memOp;
  logic [79:0]              loadExt;
  logic [5:0]               loadExc;
  logic [79:0]              storeData;
  logic [5:0]               storeExc;
  logic [5:0]               extRec;
  logic [5:0]               cvRec;
  logic [5:0]               allRec;
  logic [5:0]               unm;
  logic                     done;
  logic                     initWr;
  logic                     condWr;
  logic                     goWr;
  logic                     goLd;
  logic                     goSt;
  logic [AW-2:0]            wordAddr;
  logic [95:0]              wShift;
  logic [5:0]               remFlags;
  int                       nb;
  int                       bi;

  // The release is synchronised so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  assign initWr   = regWr && regAddr == fpeof_pkg::RA_CMD && regWdata[fpeof_pkg::CMD_INIT];
  assign condWr   = regWr && regAddr == fpeof_pkg::RA_COND;
  assign goWr     = regWr && regAddr == fpeof_pkg::RA_CMD && regWdata[fpeof_pkg::CMD_GO]
                    && !initWr && q.st == S_IDLE;
  assign goLd     = goWr && !regWdata[fpeof_pkg::CMD_STORE];
  assign goSt     = goWr && regWdata[fpeof_pkg::CMD_STORE];
  assign cvFmt    = goWr ? fpeof_pkg::fpeof_fmt_type'(regWdata[fpeof_pkg::CMD_FMT +: 3]) : q.fmt;
  assign memOp    = 80'(q.raw >> (8 * int'(q.addr[0]))); // RULE1
  assign wordAddr = q.addr[AW-1:1] + (AW-1)'(q.cnt);
  assign wShift   = q.raw << (8 * int'(q.addr[0]));

  fpeof_convert u_convert (
    .fmt       (cvFmt),
    .memOp     (memOp),
    .extIn     (q.ext),
    .loadExt   (loadExt),
    .loadExc   (loadExc),
    .storeData (storeData),
    .storeExc  (storeExc)
  );

  always_comb begin
    n = q;
    n.memRd = 1'b0;
    n.memWr = 1'b0;
    n.fixVal = 1'b0;
    n.rdData = '0;
    cvRec = '0;
    done = 1'b0;
    nb = fpeof_pkg::fmt_bytes(q.fmt);
    bi = 0;
    extRec = excValid ? resolve(excReq) : 6'h0;
    case (q.st)
      S_IDLE: begin
        if (goWr) begin
          n.fmt = cvFmt;
          n.store = regWdata[fpeof_pkg::CMD_STORE];
          n.cnt = '0;
          n.raw = '0;
          if (goSt) begin
            cvRec = resolve(storeExc);
            // An unmasked fault leaves memory untouched so the handler can retry.
            if ((cvRec & ~q.ctrl[5:0]) == 6'h0) begin
              n.raw[79:0] = storeData; // RULE8
              n.st = S_WRITE;
            end else begin
              done = 1'b1;
            end
          end else begin
            n.st = S_RISS;
          end
        end
      end
      S_RISS: begin
        n.memRd = 1'b1;
        n.memAddr = {wordAddr, 1'b0}; // RULE1
        n.st = S_RWAIT;
      end
      S_RWAIT: begin
        n.st = S_RCAP;
      end
      S_RCAP: begin
        n.raw[16 * int'(q.cnt) +: 16] = memRdata;
        n.cnt = q.cnt + 3'h1;
        n.st = (q.cnt + 3'h1 == wordsFor(q.fmt, q.addr[0])) ? S_LFIN : S_RISS; // RULE2
      end
      S_LFIN: begin
        cvRec = resolve(loadExc);
        if ((cvRec & ~q.ctrl[5:0]) == 6'h0) n.ext = loadExt; // RULE3
        done = 1'b1;
        n.st = S_IDLE;
      end
      S_WRITE: begin
        n.memWr = 1'b1;
        n.memAddr = {wordAddr, 1'b0};
        n.memWdata = wShift[16 * int'(q.cnt) +: 16]; // RULE4
        for (int k = 0; k < 2; k++) begin
          bi = 2 * int'(q.cnt) + k;
          n.memBe[k] = bi >= int'(q.addr[0]) && bi < int'(q.addr[0]) + nb; // RULE2
        end
        n.cnt = q.cnt + 3'h1;
        if (q.cnt + 3'h1 == wordsFor(q.fmt, q.addr[0])) begin
          n.st = S_IDLE;
          done = 1'b1;
        end
      end
      default: n.st = S_IDLE;
    endcase

    // Masked invalid, zero-divide, overflow and underflow conditions leave a default result for the datapath.
    if (excValid) begin
      n.fixRes = {excSign, 79'h0}; // RULE13
      if ((extRec & q.ctrl[5:0] & 6'(1 << fpeof_pkg::EXC_INV)) != 6'h0) begin
        n.fixRes = fpeof_pkg::QNAN_IND;
        n.fixVal = 1'b1;
      end else if (extRec[fpeof_pkg::EXC_ZDV] && q.ctrl[fpeof_pkg::EXC_ZDV]
                   || extRec[fpeof_pkg::EXC_OVF] && q.ctrl[fpeof_pkg::EXC_OVF]) begin
        n.fixRes = {excSign, fpeof_pkg::EXP_MAX, 1'b1, 63'h0};
        n.fixVal = 1'b1;
      end else if (extRec[fpeof_pkg::EXC_UNF] && q.ctrl[fpeof_pkg::EXC_UNF]) begin
        n.fixVal = 1'b1;
      end
    end

    allRec = extRec | cvRec;
    unm = allRec & ~q.ctrl[5:0]; // RULE12
    remFlags = q.flags & ~(condWr ? regWdata[5:0] : 6'h0);
    n.flags = remFlags | allRec;
    // Apart from a reinitialise, the summary bit drops only once software has cleared every flag.
    n.es = (q.es && !(condWr && remFlags == 6'h0)) || (unm != 6'h0); // RULE14
    n.intSt = q.intSt & ~((regWr && regAddr == fpeof_pkg::RA_INTST) ? regWdata[1:0] : 2'h0);
    n.intSt[fpeof_pkg::INT_FAULT] = n.intSt[fpeof_pkg::INT_FAULT] | (unm != 6'h0);
    n.intSt[fpeof_pkg::INT_DONE] = n.intSt[fpeof_pkg::INT_DONE] | done;

    if (regWr) begin
      case (regAddr)
        fpeof_pkg::RA_CTRL: n.ctrl = regWdata;
        fpeof_pkg::RA_INTMSK: n.intMsk = regWdata[1:0];
        fpeof_pkg::RA_ADRLO: if (q.st == S_IDLE) n.addr[15:0] = regWdata;
        fpeof_pkg::RA_ADRHI: if (q.st == S_IDLE) n.addr[AW-1:16] = regWdata[AW-17:0];
        default: begin
          for (int i = 0; i < fpeof_pkg::EXT_WORDS; i++) begin
            if (q.st == S_IDLE && regAddr == fpeof_pkg::RA_EXT0 + 4'(i))
              n.ext[16 * i +: 16] = regWdata;
          end
        end
      endcase
    end
    // Reinitialising aborts a transfer; events of that cycle still land.
    if (initWr) begin
      n.ctrl = fpeof_pkg::CTRL_RESET;
      n.flags = allRec;
      n.es = (unm != 6'h0); // RULE14
      n.st = S_IDLE;
    end

    if (regRd) begin
      case (regAddr)
        fpeof_pkg::RA_CTRL: n.rdData = q.ctrl;
        fpeof_pkg::RA_COND: n.rdData = {8'h0, q.es, 1'b0, q.flags};
        fpeof_pkg::RA_INTST: n.rdData = {14'h0, q.intSt};
        fpeof_pkg::RA_INTMSK: n.rdData = {14'h0, q.intMsk};
        fpeof_pkg::RA_CMD: n.rdData = {11'h0, q.fmt, q.store, q.st != S_IDLE};
        fpeof_pkg::RA_ADRLO: n.rdData = q.addr[15:0];
        fpeof_pkg::RA_ADRHI: n.rdData = 16'(q.addr[AW-1:16]);
        default: begin
          for (int i = 0; i < fpeof_pkg::EXT_WORDS; i++) begin
            if (regAddr == fpeof_pkg::RA_EXT0 + 4'(i)) n.rdData = q.ext[16 * i +: 16];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= REGS_RST;
    end else begin
      q <= n;
    end
  end

  assign regRdata  = q.rdData;
  assign fixValid  = q.fixVal;
  assign fixResult = q.fixRes;
  assign memAddr   = q.memAddr;
  assign memRd     = q.memRd;
  assign memWr     = q.memWr;
  assign memWdata  = q.memWdata;
  assign memBe     = q.memBe;
  assign errorN    = !q.es; // RULE9
  assign irq       = (q.intSt & q.intMsk) != 2'h0;
  assign busy      = q.st != S_IDLE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  a_fault_raise: assert property (excValid && (resolve(excReq) & ~q.ctrl[5:0]) != 6'h0 |=> !errorN && q.es) // RULE9
    else $error("unmasked exception did not raise the fault output");
  a_fault_held: assert property (!errorN && !condWr && !initWr |=> !errorN) // RULE14
    else $error("fault output dropped without a clear");
  a_masked_quiet: assert property (errorN && excValid && (excReq & ~q.ctrl[5:0]) == 6'h0 && cvRec == 6'h0 |=> errorN) // RULE8
    else $error("masked exception reported a fault");
  a_zdiv_default: assert property (excValid && excReq == 6'(1 << fpeof_pkg::EXC_ZDV) && q.ctrl[fpeof_pkg::EXC_ZDV]
    |=> fixValid && fixResult[78:64] == fpeof_pkg::EXP_MAX && fixResult[79] == $past(excSign)) // RULE13
    else $error("masked zero divide gave no infinity");
  a_prec_order: assert property (excValid && excReq[fpeof_pkg::EXC_INV] && excReq[fpeof_pkg::EXC_DEN]
    && !q.flags[fpeof_pkg::EXC_DEN] && !cvRec[fpeof_pkg::EXC_DEN] |=> !q.flags[fpeof_pkg::EXC_DEN]) // RULE7
    else $error("lower precedence exception recorded with invalid");
  a_mask_reset: assert property ($rose(rstN) |-> q.ctrl[5:0] == fpeof_pkg::CTRL_RESET[5:0]) // RULE12
    else $error("exception masks wrong after reset");
  a_lsb_first: assert property (goLd |-> ##2 memRd && memAddr == {q.addr[AW-1:1], 1'b0}) // RULE1
    else $error("load did not start at the lowest word");
  a_misalign_read: assert property (goLd && regWdata[fpeof_pkg::CMD_FMT +: 3] == fpeof_pkg::FMT_I16 && q.addr[0]
    |-> ##5 memRd) // RULE2
    else $error("misaligned word operand missed its second read");
  a_store_write: assert property (goSt && (resolve(storeExc) & ~q.ctrl[5:0]) == 6'h0 |=> q.st == S_WRITE ##1 memWr) // RULE4
    else $error("store did not reach memory");
  a_load_commit: assert property (q.st == S_LFIN && (cvRec & ~q.ctrl[5:0]) == 6'h0 |=> q.ext == $past(loadExt)) // RULE3
    else $error("converted load value not committed");
  c_load_done: cover property (q.st == S_LFIN);
  c_store_done: cover property (q.st == S_WRITE ##1 q.st == S_IDLE);
  c_fault_seen: cover property ($fell(errorN));
endmodule
